// >>> verilog/gpcs_pkg.sv
// gpcs_pkg: register map, field positions, reset values and states of the
// gigabit coding sublayer control/status block.
// assumes a 32-bit apb slave with byte addresses and one word per register.
package gpcs_pkg;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] GPCS_OFS_MAIN = 8'h00;
  localparam logic [7:0] GPCS_OFS_MODE = 8'h04;
  localparam logic [7:0] GPCS_OFS_SD = 8'h08;
  localparam logic [7:0] GPCS_OFS_ANEG = 8'h0c;
  localparam logic [7:0] GPCS_OFS_NP = 8'h10;
  localparam logic [7:0] GPCS_OFS_LB = 8'h14;
  localparam logic [7:0] GPCS_OFS_ANST = 8'h20;
  localparam logic [7:0] GPCS_OFS_LINK = 8'h28;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int GPCS_B_ENA = 0;
  localparam int GPCS_B_LSTYPE = 4;
  localparam int GPCS_B_SGMII = 0;
  localparam int GPCS_B_UNIDIR = 4;
  localparam int GPCS_B_SDUSE = 0;
  localparam int GPCS_B_SDPOL = 4;
  localparam int GPCS_B_SDSEL = 8;
  localparam int GPCS_B_ANON = 0;
  localparam int GPCS_B_RESTART = 1;
  localparam int GPCS_B_SWRES = 8;
  localparam int GPCS_B_NPLOAD = 0;
  localparam int GPCS_B_LB = 0;
  localparam int GPCS_B_DONE = 0;
  localparam int GPCS_B_PAGE = 3;
  localparam int GPCS_B_PR = 4;
  localparam int GPCS_B_SYNC = 0;
  localparam int GPCS_B_LINK = 4;
  localparam int GPCS_B_SIG = 8;
  localparam int GPCS_W_LO = 16;
  localparam int GPCS_W_HI = 31;
  localparam int GPCS_LP_LINK_BIT = 15;
  // duplex ability positions in a base page
  localparam int GPCS_B_FDX = 5;
  localparam int GPCS_B_HDX = 6;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic GPCS_RST_SGMII = 1'h1;
  localparam logic GPCS_RST_SDPOL = 1'h1;
  localparam logic GPCS_RST_SDUSE = 1'h1;
  localparam logic [15:0] GPCS_RST_WORD = 16'h0000;
  localparam logic [31:0] GPCS_ZERO32 = 32'h0000_0000;

  // negotiation states
  typedef enum logic [2:0] {
    GPCS_AN_IDLE,
    GPCS_AN_RESTART,
    GPCS_AN_ABILITY,
    GPCS_AN_ACK,
    GPCS_AN_LINK_OK,
    GPCS_AN_FAIL,
    GPCS_AN_DIS_LINK_OK
  } gpcs_an_t;

endpackage

// >>> verilog/gpcs_regs.sv
// gpcs_regs: apb register bank and negotiation control for one gigabit
// coding sublayer. the serdes data path and the partner page receiver are
// outside; they hand in sync as a level, received pages and ack as same-clock strobes.
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module gpcs_regs
  import gpcs_pkg::*;
(
  input wire logic clk_sys, // 125 mhz core clock
  input wire logic rst_n, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic sd_serdes, // detect line from serdes macro (async)
  input wire logic sd_pin, // external detect pin (async)
  input wire logic sync_ok, // pcs synchronized
  input wire logic page_rx, // strobe: partner page received
  input wire logic [15:0] page_word, // received page word
  input wire logic page_ack, // strobe: partner acknowledged
  input wire logic np_sent, // strobe: next page consumed
  output logic coding_sublayer_on, // sublayer enable
  output logic serial_gmii_select, // 1 serial gmii, 0 serdes
  output logic one_way_transmit_on, // mac may send without rx link
  output logic ten_bit_loopback_on, // loop egress to ingress, rx clk from tx
  output logic signal_present, // qualified signal detect
  output logic link_up, // negotiation link state
  output logic sys_link_status, // link indication to system
  output logic mac_tx_allow, // mac transmit permitted
  output logic [15:0] tx_config_word, // word sent in negotiation
  output logic an_restart_pulse // negotiation restart requested
);
  import gpcs_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [1:0] sds_sy;
    logic [1:0] pin_sy;
    logic ena;
    logic lstype;
    logic unidir;
    logic sgmii;
    logic sdsel;
    logic sdpol;
    logic sduse;
    logic [15:0] adv;
    logic swres;
    logic anon;
    logic restart;
    logic [15:0] np_word;
    logic np_loaded;
    logic lb;
    logic [15:0] lp_word;
    logic page_stk;
    logic done;
    gpcs_an_t an;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic sig;
    logic lnk;
    logic slink;
    logic txallow;
    logic [15:0] txw;
  } gpcs_state_t;

  gpcs_state_t s_r;
  gpcs_state_t s_nxt;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // half or full duplex common to both sides
  function automatic logic dup_match(input logic [15:0] a, input logic [15:0] b);
    return (a[GPCS_B_FDX] & b[GPCS_B_FDX]) | (a[GPCS_B_HDX] & b[GPCS_B_HDX]);
  endfunction

  logic wr;
  logic rd_access;
  logic mapped;
  logic at_main;
  logic at_mode;
  logic at_sd;
  logic at_aneg;
  logic at_np;
  logic at_lb;
  logic at_anst;
  logic at_link;
  logic sel_sd;
  logic sig_now;
  logic lnk_now;
  logic pr_now;
  logic [31:0] rd_val;

  always_comb begin
    s_nxt = s_r;

    // ****************************************************************
    // address decode
    // ****************************************************************
    at_main = hit(paddr, GPCS_OFS_MAIN);
    at_mode = hit(paddr, GPCS_OFS_MODE);
    at_sd = hit(paddr, GPCS_OFS_SD);
    at_aneg = hit(paddr, GPCS_OFS_ANEG);
    at_np = hit(paddr, GPCS_OFS_NP);
    at_lb = hit(paddr, GPCS_OFS_LB);
    at_anst = hit(paddr, GPCS_OFS_ANST);
    at_link = hit(paddr, GPCS_OFS_LINK);
    mapped = at_main | at_mode | at_sd | at_aneg | at_np | at_lb | at_anst | at_link;
    // first access cycle only; the wait cycle must not act twice
    wr = psel & penable & pwrite & ~s_r.ready;
    rd_access = psel & penable & ~pwrite & ~s_r.ready;
    s_nxt.sds_sy = {s_r.sds_sy[0], sd_serdes};
    s_nxt.pin_sy = {s_r.pin_sy[0], sd_pin};
    s_nxt.restart = 1'b0;

    // ****************************************************************
    // signal detect qualification
    // ****************************************************************
    // detect source mux
    sel_sd = s_r.sdsel ? s_r.pin_sy[1] : s_r.sds_sy[1];
    sig_now = ~s_r.sduse | (sel_sd == s_r.sdpol);

    // ****************************************************************
    // apb writes
    // ****************************************************************
    if (wr) begin
      // main: enable and link indication type
      if (at_main) begin
        s_nxt.ena = pwdata[GPCS_B_ENA];
        s_nxt.lstype = pwdata[GPCS_B_LSTYPE];
      end

      // mode: coding mode and one-way transmit
      if (at_mode) begin
        s_nxt.sgmii = pwdata[GPCS_B_SGMII];
        s_nxt.unidir = pwdata[GPCS_B_UNIDIR];
      end

      // signal detect: source, level, use
      if (at_sd) begin
        s_nxt.sdsel = pwdata[GPCS_B_SDSEL];
        s_nxt.sdpol = pwdata[GPCS_B_SDPOL];
        s_nxt.sduse = pwdata[GPCS_B_SDUSE];
      end

      if (at_aneg) begin
        s_nxt.adv = pwdata[GPCS_W_HI:GPCS_W_LO];
        s_nxt.swres = pwdata[GPCS_B_SWRES];
        s_nxt.anon = pwdata[GPCS_B_ANON];
        s_nxt.restart = pwdata[GPCS_B_RESTART];
      end

      if (at_np) begin
        s_nxt.np_word = pwdata[GPCS_W_HI:GPCS_W_LO];
        if (pwdata[GPCS_B_NPLOAD]) begin
          s_nxt.np_loaded = 1'b1;
        end
      end

      // loopback
      if (at_lb) begin
        s_nxt.lb = pwdata[GPCS_B_LB];
      end

      if (at_anst && pwdata[GPCS_B_PAGE]) begin
        s_nxt.page_stk = 1'b0;
      end
    end

    // ****************************************************************
    // negotiation state machine
    // ****************************************************************
    if (page_rx && s_r.ena) begin
      s_nxt.lp_word = page_word;
      s_nxt.page_stk = 1'b1;
    end
    if (np_sent && s_r.np_loaded) begin
      s_nxt.np_loaded = 1'b0;
    end
    unique case (s_r.an)
      GPCS_AN_IDLE: begin
        if (s_r.ena && sig_now && sync_ok) begin
          s_nxt.an = s_r.anon ? GPCS_AN_RESTART : GPCS_AN_DIS_LINK_OK;
        end
      end
      GPCS_AN_RESTART: begin
        s_nxt.done = 1'b0;
        s_nxt.an = GPCS_AN_ABILITY;
      end
      GPCS_AN_ABILITY: begin
        if (page_rx) begin
          s_nxt.an = GPCS_AN_ACK;
        end
      end
      GPCS_AN_ACK: begin
        if (page_ack) begin
          if (s_r.swres || dup_match(s_r.adv, s_r.lp_word)) begin
            s_nxt.an = GPCS_AN_LINK_OK;
            s_nxt.done = 1'b1;
          end else begin
            s_nxt.an = GPCS_AN_FAIL;
          end
        end
      end
      GPCS_AN_LINK_OK, GPCS_AN_FAIL, GPCS_AN_DIS_LINK_OK: begin
      end
      // unused code: fall back to idle
      default: begin
        s_nxt.an = GPCS_AN_IDLE;
      end
    endcase

    // disabled sublayer, loss of signal or loss of sync drops link
    if (!s_r.ena || !sig_now || !sync_ok) begin
      s_nxt.an = GPCS_AN_IDLE;
      s_nxt.done = 1'b0;
    end else if (s_r.an == GPCS_AN_DIS_LINK_OK && s_r.anon) begin
      s_nxt.an = GPCS_AN_RESTART;
    end else if ((s_r.an != GPCS_AN_DIS_LINK_OK && s_r.an != GPCS_AN_IDLE && !s_r.anon)) begin
      s_nxt.an = GPCS_AN_DIS_LINK_OK;
      s_nxt.done = 1'b0;
    end else if (s_r.restart && s_r.anon) begin
      s_nxt.an = GPCS_AN_RESTART;
    end

    // ****************************************************************
    // outputs and read data
    // ****************************************************************
    // link up states
    lnk_now = (s_r.an == GPCS_AN_LINK_OK) || (s_r.an == GPCS_AN_DIS_LINK_OK);
    pr_now = (s_r.an == GPCS_AN_ACK) || (s_r.an == GPCS_AN_LINK_OK) || (s_r.an == GPCS_AN_FAIL);
    s_nxt.sig = sig_now;
    s_nxt.lnk = lnk_now;
    s_nxt.slink = s_r.lstype ? s_r.lp_word[GPCS_LP_LINK_BIT] : sync_ok;
    s_nxt.txallow = s_r.ena & (s_r.unidir | lnk_now);
    s_nxt.txw = (s_r.an == GPCS_AN_LINK_OK && s_r.np_loaded) ? s_r.np_word : s_r.adv;

    rd_val = GPCS_ZERO32;
    // main config
    if (at_main) begin
      rd_val[GPCS_B_ENA] = s_r.ena;
      rd_val[GPCS_B_LSTYPE] = s_r.lstype;
    end

    // mode config
    if (at_mode) begin
      rd_val[GPCS_B_SGMII] = s_r.sgmii;
      rd_val[GPCS_B_UNIDIR] = s_r.unidir;
    end

    // signal detect config
    if (at_sd) begin
      rd_val[GPCS_B_SDSEL] = s_r.sdsel;
      rd_val[GPCS_B_SDPOL] = s_r.sdpol;
      rd_val[GPCS_B_SDUSE] = s_r.sduse;
    end

    // negotiation config; restart always reads 0
    if (at_aneg) begin
      rd_val[GPCS_W_HI:GPCS_W_LO] = s_r.adv;
      rd_val[GPCS_B_SWRES] = s_r.swres;
      rd_val[GPCS_B_ANON] = s_r.anon;
    end

    // next page config
    if (at_np) begin
      rd_val[GPCS_W_HI:GPCS_W_LO] = s_r.np_word;
      rd_val[GPCS_B_NPLOAD] = s_r.np_loaded;
    end

    // loopback config
    if (at_lb) begin
      rd_val[GPCS_B_LB] = s_r.lb;
    end

    // negotiation status
    if (at_anst) begin
      rd_val[GPCS_W_HI:GPCS_W_LO] = s_r.lp_word;
      rd_val[GPCS_B_PR] = pr_now;
      rd_val[GPCS_B_PAGE] = s_r.page_stk;
      rd_val[GPCS_B_DONE] = s_r.done;
    end

    // link status: live sync, registered link and signal
    if (at_link) begin
      rd_val[GPCS_B_SIG] = s_r.sig;
      rd_val[GPCS_B_LINK] = s_r.lnk;
      rd_val[GPCS_B_SYNC] = sync_ok;
    end
    // one wait state: answer the cycle after access phase starts
    s_nxt.ready = psel & penable & ~s_r.ready;
    s_nxt.err = (wr | rd_access) & ~mapped;
    if (rd_access) begin
      s_nxt.rdata = rd_val;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.sgmii <= GPCS_RST_SGMII;
      s_r.sdpol <= GPCS_RST_SDPOL;
      s_r.sduse <= GPCS_RST_SDUSE;
      s_r.adv <= GPCS_RST_WORD;
      s_r.lp_word <= GPCS_RST_WORD;
      s_r.an <= GPCS_AN_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.rdata;
  assign pready = s_r.ready;
  assign pslverr = s_r.err;
  assign coding_sublayer_on = s_r.ena;
  assign serial_gmii_select = s_r.sgmii;
  assign one_way_transmit_on = s_r.unidir;
  assign ten_bit_loopback_on = s_r.lb;
  assign signal_present = s_r.sig;
  assign link_up = s_r.lnk;
  assign sys_link_status = s_r.slink;
  assign mac_tx_allow = s_r.txallow;
  assign tx_config_word = s_r.txw;
  assign an_restart_pulse = s_r.restart;

endmodule

// >>> test/gpcs_regs_checker.sv
// gpcs_regs_checker: port-level assertions for gpcs_regs.
// assumes a bind onto gpcs_regs; one clock, async active-low reset.
`timescale 1ns/1ps
module gpcs_regs_checker
  import gpcs_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic rst_n, // reset
  input wire logic psel, // select
  input wire logic penable, // access
  input wire logic pwrite, // direction
  input wire logic [7:0] paddr, // address
  input wire logic [31:0] pwdata, // write data
  input wire logic pready, // ready
  input wire logic sync_ok, // sync
  input wire logic coding_sublayer_on, // enable
  input wire logic one_way_transmit_on, // one-way
  input wire logic ten_bit_loopback_on, // loopback
  input wire logic link_up, // link
  input wire logic mac_tx_allow, // tx permit
  input wire logic an_restart_pulse // restart
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // ****************
  // write sequence
  // ****************
  sequence s_wr(logic [7:0] a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence
  property p_mirror(logic [7:0] a, int b, logic o);
    s_wr(a) |=> ##1 (o == $past(pwdata[b], 2));
  endproperty
  // ****************
  // assertions
  // ****************
  AST_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  AST_LB_MIRROR: assert property (p_mirror(GPCS_OFS_LB, GPCS_B_LB, ten_bit_loopback_on))
    else $error("loopback output wrong");
  AST_ENA_MIRROR: assert property (p_mirror(GPCS_OFS_MAIN, GPCS_B_ENA, coding_sublayer_on))
    else $error("enable output wrong");
  AST_UNIDIR_MIRROR: assert property (p_mirror(GPCS_OFS_MODE, GPCS_B_UNIDIR, one_way_transmit_on))
    else $error("one-way output wrong");
  AST_ONE_WAY_TX: assert property (one_way_transmit_on && coding_sublayer_on && $past(one_way_transmit_on)
    && $past(coding_sublayer_on) |-> mac_tx_allow)
    else $error("one-way tx blocked");
  AST_OFF_NO_TX: assert property (!coding_sublayer_on && !$past(coding_sublayer_on) |-> !mac_tx_allow)
    else $error("tx while disabled");
  AST_LINK_CAUSE: assert property (link_up |-> $past(sync_ok, 2) && $past(coding_sublayer_on, 2))
    else $error("link up without cause");
  AST_RESTART_ONCE: assert property (an_restart_pulse |=> !an_restart_pulse)
    else $error("restart not self-clearing");
  AST_RESTART_PULSE: assert property (s_wr(GPCS_OFS_ANEG) |-> an_restart_pulse == pwdata[GPCS_B_RESTART])
    else $error("restart pulse wrong");
endmodule

// >>> test/gpcs_lp_model.sv
// gpcs_lp_model: link partner side, detect lines, sync and page strobes.
// assumes its tasks are called from one bench process.
`timescale 1ns/1ps
module gpcs_lp_model (
  input wire logic clk_sys, // clock
  output logic sd_serdes, // serdes detect
  output logic sd_pin, // external detect
  output logic sync_ok, // sync level
  output logic page_rx, // page strobe
  output logic [15:0] page_word, // page word
  output logic page_ack, // ack strobe
  output logic np_sent // next page taken
);
  initial begin
    {sd_serdes, sd_pin, sync_ok, page_rx, page_ack, np_sent} = 6'h0;
    page_word = 16'h0000;
  end
  task automatic lines(input logic s, input logic p, input logic y);
    @(posedge clk_sys);
    sd_serdes <= s;
    sd_pin <= p;
    sync_ok <= y;
  endtask
  // kind 0 page, 1 ack, 2 next page taken; word inverted when idle
  task automatic strobe(input int k, input logic [15:0] w);
    @(posedge clk_sys);
    {page_rx, page_ack, np_sent} <= {k == 0, k == 1, k == 2};
    page_word <= w;
    @(posedge clk_sys);
    {page_rx, page_ack, np_sent} <= 3'h0;
    page_word <= ~w;
  endtask
endmodule

// >>> test/gpcs_regs_tb_top.sv
// gpcs_regs_tb_top: directed bench for gpcs_regs over apb.
// assumes gpcs_lp_model drives every far-side input.
`timescale 1ns/1ps
module gpcs_regs_tb_top;
  import gpcs_pkg::*;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, err_q;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic sd_serdes, sd_pin, sync_ok, page_rx, page_ack, np_sent;
  logic [15:0] page_word, tx_config_word;
  logic coding_sublayer_on, serial_gmii_select, one_way_transmit_on, ten_bit_loopback_on;
  logic signal_present, link_up, sys_link_status, mac_tx_allow, an_restart_pulse;
  int n_mismatch = 0;
  int n_tests = 0;
  gpcs_regs gpcs_regs_inst (.*);
  gpcs_lp_model gpcs_lp_model_inst (.*);
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 40);
    q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 40) begin
      $display("CHECK FAILED %0t apb timeout", $time);
      n_mismatch++;
      finish_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q & m, x);
  endtask
  task automatic settle();
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic t_reset();
    rc(GPCS_OFS_MAIN, ALL, 32'h0);
    rc(GPCS_OFS_MODE, ALL, 32'h1);
    rc(GPCS_OFS_SD, ALL, 32'h11);
    rc(GPCS_OFS_ANEG, ALL, 32'h0);
    rc(GPCS_OFS_NP, ALL, 32'h0);
    rc(GPCS_OFS_ANST, ALL, 32'h0);
    settle();
    chk(serial_gmii_select, 32'h1);
  endtask
  task automatic t_cfg();
    logic [31:0] q;
    wr(GPCS_OFS_LB, 32'h1);
    wr(GPCS_OFS_MODE, 32'h10);
    settle();
    chk({ten_bit_loopback_on, serial_gmii_select, one_way_transmit_on, mac_tx_allow}, 32'ha);
    wr(GPCS_OFS_MAIN, 32'h1);
    settle();
    chk({coding_sublayer_on, mac_tx_allow}, 32'h3);
    wr(GPCS_OFS_MODE, 32'h0);
    settle();
    chk(mac_tx_allow, 32'h0);
    rc(GPCS_OFS_LB, ALL, 32'h1);
    apb(1'b0, 8'h18, 32'h0, q);
    chk(q, 32'h0);
    chk(err_q, 32'h1);
    wr(GPCS_OFS_LB, 32'h0);
  endtask
  task automatic t_sig();
    logic [3:0] i;
    for (int k = 0; k < 16; k++) begin
      i = 4'(k);
      wr(GPCS_OFS_SD, {23'h0, i[2], 3'h0, i[1], 3'h0, i[0]});
      gpcs_lp_model_inst.lines(i[2] ? ~i[3] : i[3], i[2] ? i[3] : ~i[3], 1'b0);
      settle();
      chk(signal_present, 32'(!i[0] || i[3] == i[1]));
      rc(GPCS_OFS_LINK, 32'h100, {23'h0, !i[0] || i[3] == i[1], 8'h0});
    end
  endtask
  task automatic t_aneg();
    logic [15:0] w;
    wr(GPCS_OFS_SD, 32'h11);
    gpcs_lp_model_inst.lines(1'b1, 1'b0, 1'b1);
    wr(GPCS_OFS_ANEG, 32'h0020_0000);
    settle();
    chk({link_up, tx_config_word}, {1'b1, 16'h0020});
    for (int k = 0; k < 3; k++) begin
      w = (k == 0) ? 16'h8020 : 16'h0040;
      wr(GPCS_OFS_ANEG, {16'h0020, 7'h0, k == 2, 8'h03});
      rc(GPCS_OFS_ANEG, 32'h2, 32'h0);
      settle();
      gpcs_lp_model_inst.strobe(0, w);
      rc(GPCS_OFS_ANST, ALL, {w, 16'h0018});
      chk(link_up, 32'h0);
      gpcs_lp_model_inst.strobe(1, 16'h0);
      settle();
      chk(link_up, 32'(k != 1));
      rc(GPCS_OFS_ANST, 32'h1, 32'(k != 1));
    end
    wr(GPCS_OFS_ANST, 32'h0);
    rc(GPCS_OFS_ANST, 32'h8, 32'h8);
    wr(GPCS_OFS_ANST, 32'h8);
    rc(GPCS_OFS_ANST, 32'h8, 32'h0);
    wr(GPCS_OFS_MAIN, 32'h11);
    settle();
    chk(sys_link_status, 32'h0);
    wr(GPCS_OFS_MAIN, 32'h1);
    settle();
    chk(sys_link_status, 32'h1);
  endtask
  task automatic t_np();
    wr(GPCS_OFS_NP, 32'habcd_0000);
    wr(GPCS_OFS_NP, 32'habcd_0001);
    rc(GPCS_OFS_NP, ALL, 32'habcd_0001);
    settle();
    chk(tx_config_word, 32'habcd);
    gpcs_lp_model_inst.strobe(2, 16'h0);
    rc(GPCS_OFS_NP, ALL, 32'habcd_0000);
  endtask
  task automatic t_rerun();
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    chk({link_up, mac_tx_allow, tx_config_word}, 32'h0);
  endtask
  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_cfg();
    t_sig();
    t_aneg();
    t_np();
    t_rerun();
    finish_test();
  end
endmodule
bind gpcs_regs gpcs_regs_checker gpcs_regs_checker_inst (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .sync_ok(sync_ok),
  .coding_sublayer_on(coding_sublayer_on), .one_way_transmit_on(one_way_transmit_on),
  .ten_bit_loopback_on(ten_bit_loopback_on), .link_up(link_up), .mac_tx_allow(mac_tx_allow),
  .an_restart_pulse(an_restart_pulse));
